/* File: oacc_regs.vh */
`ifndef OACC_REGS_VH
`define OACC_REGS_VH
// Byte addresses on the AHB-Lite slave
`define OACC_ADDR_CSR 12'h000
`define OACC_ADDR_IRQ_STAT 12'h004
`define OACC_ADDR_IRQ_EN 12'h008
`define OACC_ADDR_IRQ_CLR 12'h00C
// Control/status fields
`define OACC_BIT_DONE 7
`define OACC_BIT_REQ 6
`define OACC_BIT_AVG 5
`define OACC_BIT_PON 4
`define OACC_BIT_GAIN 3
`define OACC_CSR_RESET 8'h00
`define OACC_CSR_WMASK 8'h7F
// Interrupt status bits
`define OACC_IRQ_DONE 0
`define OACC_IRQ_ABORT 1
`define OACC_IRQ_W 2
// Compensation timing
`define OACC_AVG_PASSES 5'h10
`define OACC_PASS_NS 5000
`define OACC_CLK_NS 50
`define OACC_PASS_CYC (`OACC_PASS_NS / `OACC_CLK_NS)
`define OACC_STAB_NS 10000
`define OACC_STAB_CYC (`OACC_STAB_NS / `OACC_CLK_NS)
`endif

/* File: oacc_ctrl.v */
// Summary of operation
// R01 - Writing request one starts compensation cycle
// R02 - Hardware sets done flag when cycle ends
// R03 - Correction held only while request is one
// R04 - Software toggles request zero-one for rerun
// R05 - Average select gives 16 passes, else one
// R06 - Done reads zero unless completed with request
// R07 - Power bit powers amplifier and connects pins
// R08 - Output high impedance while amplifier is off
// R09 - Halt disables amplifier; stabilize after wake
// R10 - Software sets gain bit above 20dB gain
// R11 - Software keeps lowest three bits zero
// R12 - Register resets zero; top bit read-only
// R13 - Clearing request aborts cycle, drops correction
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "oacc_regs.vh"
module oacc_ctrl #(
  parameter PASS_CYC = `OACC_PASS_CYC,
  parameter STAB_CYC = `OACC_STAB_CYC
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Power mode from the system
  input wire halt_mode,
  // Analog core
  output reg amp_enable,
  output reg amp_out_oe_n,
  output reg amp_in_connect,
  output reg amp_high_gain,
  output reg comp_sample,
  output reg comp_apply,
  output reg comp_clear,
  input wire comp_pass_done,
  // Interrupt
  output reg irq
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [7:0] csr_q;
  reg [1:0] state_q;
  reg [4:0] pass_q;
  reg [15:0] timer_q;
  reg [15:0] stab_q;
  reg [2:0] halt_sync_q;
  reg halt_q;
  reg [`OACC_IRQ_W-1:0] stat_q;
  reg [`OACC_IRQ_W-1:0] en_q;
  reg wr_pend_q;
  reg [11:0] wr_addr_q;
  reg req_prev_q;
  reg [`OACC_IRQ_W-1:0] ev;
  reg [31:0] rd_d;
  wire addr_ok;
  wire wr_csr;
  wire req_rise;
  wire req_now;
  wire pass_end;
  wire last_pass;
  wire stable;
  reg [7:0] csr_d;
  reg [1:0] state_d;
  reg [4:0] pass_d;
  reg [15:0] timer_d;
  reg [15:0] stab_d;
  reg [`OACC_IRQ_W-1:0] stat_d;
  wire [7:0] wr_byte;
  wire wr_en;
  wire wr_clr;
  wire req_clr_wr;
  wire in_run;
  wire done_set;
  wire amp_on;

  function [31:0] oacc_word;
    input [7:0] v;
    begin
      oacc_word = {24'h00_0000, v};
    end
  endfunction

  // Register hit in the data phase of a pending write
  function oacc_hit;
    input pend;
    input [11:0] a;
    input [11:0] target;
    begin
      oacc_hit = pend & (a == target);
    end
  endfunction

  // Down counter that rests at zero instead of wrapping
  function [15:0] oacc_dec;
    input [15:0] v;
    begin
      if (v == 16'h0000) begin
        oacc_dec = 16'h0000;
      end else begin
        oacc_dec = v - 16'h0001;
      end
    end
  endfunction

  assign addr_ok = hsel & hready & htrans[1];
  assign wr_csr = oacc_hit(wr_pend_q, wr_addr_q, `OACC_ADDR_CSR);
  assign wr_en = oacc_hit(wr_pend_q, wr_addr_q, `OACC_ADDR_IRQ_EN);
  assign wr_clr = oacc_hit(wr_pend_q, wr_addr_q, `OACC_ADDR_IRQ_CLR);
  assign wr_byte = hwdata[7:0] & `OACC_CSR_WMASK;
  assign req_clr_wr = wr_csr & ~hwdata[`OACC_BIT_REQ];
  assign req_now = csr_q[`OACC_BIT_REQ];
  // A run whose request is already gone must not report completion
  assign in_run = (state_q == ST_RUN) & req_now;
  assign done_set = in_run & pass_end & last_pass;
  assign amp_on = csr_q[`OACC_BIT_PON] & ~halt_q;
  assign req_rise = req_now & ~req_prev_q;
  // Pass ends on core strobe or on local timer, whichever first
  assign pass_end = comp_pass_done | (timer_q == 16'h0000);
  assign last_pass = csr_q[`OACC_BIT_AVG] ? (pass_q == `OACC_AVG_PASSES - 5'h01) : 1'b1;
  assign stable = (stab_q == 16'h0000);

  // Bus write data phase, no wait states
  always @(posedge clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  always @* begin
    case (haddr)
      `OACC_ADDR_CSR: rd_d = oacc_word(csr_q);
      `OACC_ADDR_IRQ_STAT: rd_d = {30'h0000_0000, stat_q};
      `OACC_ADDR_IRQ_EN: rd_d = {30'h0000_0000, en_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Halt pin: three stages, change taken when last two agree
  always @(posedge clk) begin
    if (reset) begin
      halt_sync_q <= 3'b000;
      halt_q <= 1'b0;
    end else begin
      halt_sync_q <= {halt_sync_q[1:0], halt_mode};
      if (halt_sync_q[1] == halt_sync_q[2]) begin
        halt_q <= halt_sync_q[2];
      end
    end
  end

  // Control/status register; done bit is hardware owned
  always @* begin
    csr_d = csr_q;
    if (wr_csr) begin
      csr_d[6:0] = wr_byte[6:0]; // [R12]
    end
    // A request written low wins over a run ending on the same edge
    if (req_clr_wr) begin
      csr_d[`OACC_BIT_DONE] = 1'b0; // [R06] [R13]
    end else if (done_set) begin
      csr_d[`OACC_BIT_DONE] = 1'b1; // [R02]
    end else if (req_rise) begin
      csr_d[`OACC_BIT_DONE] = 1'b0; // [R06]
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      csr_q <= `OACC_CSR_RESET; // [R12]
      req_prev_q <= 1'b0;
    end else begin
      csr_q <= csr_d;
      req_prev_q <= req_now;
    end
  end

  // Compensation sequencer
  // Each pass ends on the core strobe or the local limit, so a silent core cannot hang it
  always @* begin
    state_d = state_q;
    pass_d = pass_q;
    timer_d = timer_q;
    if (~req_now) begin
      state_d = ST_IDLE; // [R13]
      pass_d = 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // A fresh cycle needs a zero-then-one on the request bit
          if (req_rise) begin // [R01] [R04]
            state_d = ST_RUN;
            pass_d = 5'h00;
            timer_d = PASS_CYC[15:0];
          end
        end
        ST_RUN: begin
          if (pass_end) begin
            if (last_pass) begin // [R05]
              state_d = ST_DONE;
            end else begin
              pass_d = pass_q + 5'h01;
              timer_d = PASS_CYC[15:0];
            end
          end else begin
            timer_d = oacc_dec(timer_q);
          end
        end
        ST_DONE: begin
          // Result held until the request is dropped
          state_d = ST_DONE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      pass_q <= 5'h00;
      timer_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      pass_q <= pass_d;
      timer_q <= timer_d;
    end
  end

  // Stabilization countdown after halt wake-up
  // Reloaded for the whole halt, so the count starts only on wake
  always @* begin
    if (halt_q) begin
      stab_d = STAB_CYC[15:0]; // [R09]
    end else begin
      stab_d = oacc_dec(stab_q);
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      stab_q <= 16'h0000;
    end else begin
      stab_q <= stab_d;
    end
  end

  // Analog controls, all registered
  always @(posedge clk) begin
    if (reset) begin
      amp_enable <= 1'b0;
      amp_out_oe_n <= 1'b1;
      amp_in_connect <= 1'b0;
      amp_high_gain <= 1'b0;
      comp_sample <= 1'b0;
      comp_apply <= 1'b0;
      comp_clear <= 1'b1;
    end else begin
      amp_enable <= amp_on; // [R07] [R09]
      amp_in_connect <= amp_on; // [R07]
      // Output stays released until the amplifier has settled after wake-up
      amp_out_oe_n <= ~(amp_on & stable); // [R08] [R09]
      amp_high_gain <= csr_q[`OACC_BIT_GAIN];
      comp_sample <= (state_q == ST_RUN) & req_now;
      comp_apply <= (state_q == ST_DONE) & req_now; // [R03]
      comp_clear <= ~req_now; // [R03] [R13]
    end
  end

  // Interrupt status: set wins over clear
  always @* begin
    ev = {`OACC_IRQ_W{1'b0}};
    ev[`OACC_IRQ_DONE] = done_set;
    ev[`OACC_IRQ_ABORT] = (state_q == ST_RUN) & req_clr_wr;
  end

  // An event in the cycle of its clear must not be lost
  always @* begin
    if (wr_clr) begin
      stat_d = (stat_q & ~hwdata[`OACC_IRQ_W-1:0]) | ev;
    end else begin
      stat_d = stat_q | ev;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      stat_q <= {`OACC_IRQ_W{1'b0}};
      en_q <= {`OACC_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (wr_en) begin
        en_q <= hwdata[`OACC_IRQ_W-1:0];
      end
      // One cycle behind status, so the pin never glitches on a decode
      irq <= |(stat_q & en_q);
    end
  end
endmodule
`default_nettype wire

/* File: oacc_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module oacc_ctrl_chk #(
  parameter PASS_CYC = 100,
  parameter STAB_CYC = 200
) (
  input wire logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, halt_mode, irq,
  input wire logic amp_enable, amp_out_oe_n, amp_in_connect, amp_high_gain,
  input wire logic comp_sample, comp_apply, comp_clear, comp_pass_done,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_start_run: assert property ($fell(comp_clear) |-> ##[0:2] comp_sample)
    else $error("no run after request");
  chk_done_after: assert property ($rose(comp_apply) |-> $past(comp_sample))
    else $error("apply without a run");
  chk_apply_req: assert property (comp_apply |-> !comp_clear)
    else $error("apply while cleared");
  chk_run_noapply: assert property (comp_sample |-> !comp_apply)
    else $error("apply during run");
  chk_clear_idle: assert property (comp_clear [*2] |-> !comp_sample)
    else $error("run kept after clear");
  chk_conn_pwr: assert property (amp_in_connect == amp_enable)
    else $error("pins not tied to power");
  chk_off_hiz: assert property (!amp_enable [*2] |-> amp_out_oe_n)
    else $error("output driven while off");
  chk_halt_off: assert property (halt_mode [*6] |-> !amp_enable)
    else $error("powered in halt");
  cover property (comp_apply);
  cover property ($rose(irq));
  cover property (halt_mode [*5]);
endmodule
bind oacc_ctrl oacc_ctrl_chk #(.PASS_CYC(PASS_CYC), .STAB_CYC(STAB_CYC)) u_chk (.clk(clk),
  .reset(reset), .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .halt_mode(halt_mode), .irq(irq), .amp_enable(amp_enable),
  .amp_out_oe_n(amp_out_oe_n), .amp_in_connect(amp_in_connect),
  .amp_high_gain(amp_high_gain), .comp_sample(comp_sample), .comp_apply(comp_apply),
  .comp_clear(comp_clear), .comp_pass_done(comp_pass_done), .haddr(haddr),
  .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata));
`default_nettype wire

/* File: oacc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module oacc_core_model (
  input wire logic clk,
  input wire logic comp_sample,
  input wire logic slow,
  output logic comp_pass_done
);
  // A slow core never answers, so each pass runs to the design's own limit
  initial comp_pass_done = 1'b0;
  always @(posedge clk) begin
    comp_pass_done <= comp_sample && !slow && !comp_pass_done;
  end
endmodule
`default_nettype wire

/* File: oacc_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module oacc_ctrl_tb_top;
  logic clk, reset, hsel, hwrite, halt_mode, slow;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, q, r, s;
  wire [31:0] hrdata;
  wire hreadyout, hresp, amp_enable, amp_out_oe_n, amp_in_connect, amp_high_gain;
  wire comp_sample, comp_apply, comp_clear, comp_pass_done, irq;
  wire hready = hreadyout;
  int err_count, total_checks, m, i;
  oacc_ctrl #(.PASS_CYC(3), .STAB_CYC(2)) i_dut (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .halt_mode(halt_mode), .amp_enable(amp_enable), .amp_out_oe_n(amp_out_oe_n),
    .amp_in_connect(amp_in_connect), .amp_high_gain(amp_high_gain),
    .comp_sample(comp_sample), .comp_apply(comp_apply), .comp_clear(comp_clear),
    .comp_pass_done(comp_pass_done), .irq(irq));
  oacc_core_model i_core(.clk(clk), .comp_sample(comp_sample), .slow(slow),
    .comp_pass_done(comp_pass_done));
  function [31:0] xs;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    xs = s;
  endfunction
  task ck(string n, input [31:0] v, input [31:0] e);
    total_checks++;
    if (v !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, v);
    end
  endtask
  task bus(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    hsel <= 1; htrans <= 2; hwrite <= w; haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    bus(1, a, d);
    if (a == 0) m = d & 8'h7F;
  endtask
  task rd(input [11:0] a);
    bus(0, a, 0);
  endtask
  task final_report;
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count++;
    final_report;
  end
  initial begin
    reset <= 1; hsel <= 0; htrans <= 0; hwrite <= 0; haddr <= 0; hsize <= 3'h2;
    hwdata <= 0; halt_mode <= 0; slow <= 1; m = 0; s = 96447;
    repeat (2) @(posedge clk);
    reset <= 0;
    rd(0); ck("csr", q, m);
    ck("oe", amp_out_oe_n, 1);
    ck("resp", {hresp, hreadyout}, 1);
    for (i = 0; i < 4; i++) begin
      r = xs() & 8'hB8;
      wr(0, r); rd(0); ck("csr", q, m);
      ck("pwr", amp_enable, m[4]);
      ck("conn", amp_in_connect, m[4]);
      ck("gain", amp_high_gain, m[3]);
    end
    wr(0, 'h50); rd(0); ck("run", q, m);
    ck("smp", comp_sample, 1);
    do rd(0); while (!q[7]);
    ck("done", q, m | 'h80);
    ck("apl", comp_apply, 1);
    wr(0, 'h10); rd(0); ck("zero", q, m);
    ck("clr", comp_clear, 1);
    wr(0, 'h70); repeat (40) @(posedge clk);
    rd(0); ck("avg", q, m);
    do rd(0); while (!q[7]);
    ck("avgd", q, m | 'h80);
    slow <= 0;
    wr(8, 3); wr(0, 'h30); wr(0, 'h70); wr(0, 'h30);
    rd(4); ck("stat", q, 3);
    ck("irq", irq, 1);
    wr(8, 0); rd(16); ck("unmap", q, 0);
    ck("mask", irq, 0);
    wr(12, 3); wr(8, 3); rd(4); ck("cleared", q, 0);
    ck("irq", irq, 0);
    wr(0, 'h10); halt_mode <= 1; repeat (6) @(posedge clk);
    ck("halt", amp_enable, 0);
    halt_mode <= 0; repeat (16) @(posedge clk);
    ck("wake", amp_enable, 1);
    ck("on", amp_out_oe_n, 0);
    wr(0, 0); rd(0); ck("off", amp_out_oe_n, 1);
    final_report;
  end
endmodule
`default_nettype wire
